//--- hw/acc_aux_converter_control.sv
// Purpose: Auxiliary converter and baseband reference control registers
// Assumes: Single 25 MHz clock pclk, async active-low reset presetn
// Notes:   Converter analog cores sit outside; this block drives their controls
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE1: Bit 0 powers auxiliary ADC
// RULE2: Bits 1-3 power ramp, gain, freq DACs
// RULE3: Bit 6 puts freq DAC low-power
// RULE4: Writing 1 to bit 7 starts conversion
// RULE5: Start bit is one-shot pulse
// RULE6: Bits 8-9 select ADC channel
// RULE7: Reset bit resets converters, clears data
// RULE8: Standby bit puts reference in standby
// RULE9: In standby only freq DAC drives
// RULE10: Joint bit updates main and fine on fine write
// RULE11: All control bits reset to zero
// RULE12: Software writes reserved bits as zero
// RULE13: All converters off powers reference down
// RULE14: Any converter on powers reference up
// RULE15: Keep-on bit holds reference powered
// RULE16: Level bit selects low or high output
// RULE17: Buffer-enable zero disables pin buffer
// RULE18: Pin-disable makes reference pin an input
module acc_aux_converter_control
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  input  wire logic [3:0]     pstrb,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // Baseband converter power state from the rest of the codec
  input  wire logic           bb_conv_powered,
  // Auxiliary ADC
  input  wire logic           aux_adc_busy,
  // Converter controls
  output acc_conv_ctrl_t      conv_ctrl,
  output logic                conv_outputs_enable,
  output logic                freq_out_enable,
  output acc_freq_dac_t       freq_dac,
  // Reference controls and pin
  output acc_ref_ctrl_t       ref_ctrl,
  output logic                buffered_ref_pin_oe
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       wr_en;
  logic       hit;
  logic       wr_a;
  logic       wr_b;
  logic       wr_bb;
  logic       wr_main;
  logic       wr_fine;
  logic       adc_busy_s1_r;
  logic       adc_busy_s2_r;
  logic       bb_pw_s1_r;
  logic       bb_pw_s2_r;

  assign hit = (paddr == ACC_OFS_CTRL_A) || (paddr == ACC_OFS_CTRL_B) ||
               (paddr == ACC_OFS_BB_B)   || (paddr == ACC_OFS_FMAIN)  ||
               (paddr == ACC_OFS_FFINE)  || (paddr == ACC_OFS_STATUS);
  // No wait states: every access phase completes at once
  assign pready  = 1'b1;
  // Unmapped addresses answer with an error and are ignored
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && hit;
  assign wr_a    = wr_en && (paddr == ACC_OFS_CTRL_A);
  assign wr_b    = wr_en && (paddr == ACC_OFS_CTRL_B);
  assign wr_bb   = wr_en && (paddr == ACC_OFS_BB_B);
  assign wr_main = wr_en && (paddr == ACC_OFS_FMAIN);
  assign wr_fine = wr_en && (paddr == ACC_OFS_FFINE);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two-stage synchroniser for the converter busy level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_busy_s1_r <= 1'b0;
      adc_busy_s2_r <= 1'b0;
    end else begin
      adc_busy_s1_r <= aux_adc_busy;
      adc_busy_s2_r <= adc_busy_s1_r;
    end
  end

  // Two-stage synchroniser for the baseband power level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_pw_s1_r <= 1'b0;
      bb_pw_s2_r <= 1'b0;
    end else begin
      bb_pw_s1_r <= bb_conv_powered;
      bb_pw_s2_r <= bb_pw_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [9:0] ctrl_a_r;
  logic [9:0] ctrl_b_r;
  logic [3:0] bb_b_r;
  logic       start_r;

  // RULE11: zero after reset
  // RULE12: reserved bits held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r <= ACC_RST_CTRL_A;
    end else if (wr_a && pstrb[0] && pstrb[1]) begin
      ctrl_a_r <= pwdata[9:0] & ACC_CTRL_A_WMASK;
    end
  end

  // Converter reset, reference standby and joint update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_r <= ACC_RST_CTRL_B;
    end else if (wr_b && pstrb[0]) begin
      ctrl_b_r <= pwdata[9:0] & ACC_CTRL_B_WMASK;
    end
  end

  // Reference buffer, level, pin and keep-on bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_b_r <= ACC_RST_BB_B;
    end else if (wr_bb && pstrb[0]) begin
      bb_b_r <= pwdata[3:0];
    end
  end

  // RULE4: start on written one
  // RULE5: single-cycle pulse, never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr_a && pstrb[0] && pwdata[ACC_A_START] && !ctrl_b_r[ACC_B_RESET];
    end
  end

  // ----------------------------------------------------------------
  // Frequency DAC data
  // ----------------------------------------------------------------
  logic [7:0] main_r;
  logic [9:0] fine_r;
  logic [7:0] main_out_r;
  logic [9:0] fine_out_r;
  logic       load_r;
  logic       joint;
  logic       conv_reset;
  logic       main_we;
  logic       fine_we;

  assign joint      = ctrl_b_r[ACC_B_JOINT];
  assign conv_reset = ctrl_b_r[ACC_B_RESET];
  assign main_we    = wr_main && pstrb[0];
  assign fine_we    = wr_fine && pstrb[0] && pstrb[1];

  // Words as written, read back over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_r <= 8'h00;
      fine_r <= 10'h000;
    end else if (conv_reset) begin
      main_r <= 8'h00;
      fine_r <= 10'h000;
    end else begin
      if (main_we) begin
        main_r <= pwdata[7:0];
      end
      if (fine_we) begin
        fine_r <= pwdata[9:0];
      end
    end
  end

  // Words presented to the converter
  // Joint mode defers the main word until the fine word arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_out_r <= 8'h00;
      fine_out_r <= 10'h000;
    end else if (conv_reset) begin
      // RULE7: converter data cleared
      main_out_r <= 8'h00;
      fine_out_r <= 10'h000;
    end else if (fine_we) begin
      fine_out_r <= pwdata[9:0];
      // RULE10: main follows fine write
      if (joint) begin
        main_out_r <= main_r;
      end
    end else if (main_we && !joint) begin
      main_out_r <= pwdata[7:0];
    end
  end

  // One-cycle update strobe after a fine write, or a main write outside joint mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_r <= 1'b0;
    end else begin
      load_r <= !conv_reset && (fine_we || (main_we && !joint));
    end
  end

  // ----------------------------------------------------------------
  // Converter outputs
  // ----------------------------------------------------------------
  logic any_conv_on;
  logic standby;

  assign standby = ctrl_b_r[ACC_B_STANDBY];

  always_comb begin
    // RULE1: ADC power
    conv_ctrl.adc_power_on     = ctrl_a_r[ACC_A_ADC_ON];
    // RULE2: DAC power
    conv_ctrl.ramp_power_on    = ctrl_a_r[ACC_A_RAMP_ON];
    conv_ctrl.gain_power_on    = ctrl_a_r[ACC_A_GAIN_ON];
    conv_ctrl.freq_power_on    = ctrl_a_r[ACC_A_FREQ_ON];
    // RULE3: clockless hold mode
    conv_ctrl.freq_low_power   = ctrl_a_r[ACC_A_FREQ_LP];
    // RULE6: channel select
    conv_ctrl.adc_chan         = {ctrl_a_r[ACC_A_CHAN_HI], ctrl_a_r[ACC_A_CHAN_LO]};
    conv_ctrl.adc_start        = start_r;
    // RULE7: converter reset
    conv_ctrl.converters_reset = ctrl_b_r[ACC_B_RESET];
  end

  // RULE9: standby gates all but freq DAC
  assign conv_outputs_enable = !standby;
  assign freq_out_enable     = ctrl_a_r[ACC_A_FREQ_ON];

  assign freq_dac.main_word = main_out_r;
  assign freq_dac.fine_word = fine_out_r;
  assign freq_dac.load      = load_r;

  // ----------------------------------------------------------------
  // Reference control
  // ----------------------------------------------------------------
  // Converter power requests from both sections
  // RULE13: all off, reference off
  // RULE14: any on, reference on
  assign any_conv_on = bb_pw_s2_r | ctrl_a_r[ACC_A_ADC_ON] | ctrl_a_r[ACC_A_RAMP_ON] |
                       ctrl_a_r[ACC_A_GAIN_ON] | ctrl_a_r[ACC_A_FREQ_ON];

  always_comb begin
    // RULE15: keep-on overrides
    ref_ctrl.ref_power_on   = any_conv_on | bb_b_r[ACC_BB_KEEP_ON];
    // RULE8: standby state
    ref_ctrl.ref_standby    = standby;
    // RULE16: output level
    ref_ctrl.ref_level_high = bb_b_r[ACC_BB_LEVEL];
    // RULE17: buffer enable
    ref_ctrl.ref_buffer_on  = bb_b_r[ACC_BB_BUF_EN] & !bb_b_r[ACC_BB_PIN_DIS];
    // RULE18: pin becomes input
    ref_ctrl.ref_pin_drive  = bb_b_r[ACC_BB_BUF_EN] & !bb_b_r[ACC_BB_PIN_DIS];
  end

  assign buffered_ref_pin_oe = ref_ctrl.ref_pin_drive;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [2:0] status_w;

  // Status: ADC busy, reference standby, reference powered
  assign status_w = {adc_busy_s2_r, standby, ref_ctrl.ref_power_on};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ACC_OFS_CTRL_A: prdata <= {22'h000000, ctrl_a_r};
        ACC_OFS_CTRL_B: prdata <= {22'h000000, ctrl_b_r};
        ACC_OFS_BB_B:   prdata <= {28'h0000000, bb_b_r};
        ACC_OFS_FMAIN:  prdata <= {24'h000000, main_r};
        ACC_OFS_FFINE:  prdata <= {22'h000000, fine_r};
        ACC_OFS_STATUS: prdata <= {29'h0, status_w};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : acc_aux_converter_control
`default_nettype wire

//--- hw/acc_pkg.sv
// Purpose: Constants and carrier types for the auxiliary converter control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register offsets are byte addresses
package acc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_OFS_CTRL_A   = 8'h00;
  localparam logic [7:0] ACC_OFS_CTRL_B   = 8'h04;
  localparam logic [7:0] ACC_OFS_BB_B     = 8'h08;
  localparam logic [7:0] ACC_OFS_FMAIN    = 8'h0c;
  localparam logic [7:0] ACC_OFS_FFINE    = 8'h10;
  localparam logic [7:0] ACC_OFS_STATUS   = 8'h14;

  localparam logic [9:0] ACC_RST_CTRL_A   = 10'h000;
  localparam logic [9:0] ACC_RST_CTRL_B   = 10'h000;
  localparam logic [3:0] ACC_RST_BB_B     = 4'h0;
  localparam logic [9:0] ACC_CTRL_A_WMASK = 10'h34f;
  localparam logic [9:0] ACC_CTRL_B_WMASK = 10'h007;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACC_A_ADC_ON   = 0;
  localparam int ACC_A_RAMP_ON  = 1;
  localparam int ACC_A_GAIN_ON  = 2;
  localparam int ACC_A_FREQ_ON  = 3;
  localparam int ACC_A_FREQ_LP  = 6;
  localparam int ACC_A_START    = 7;
  localparam int ACC_A_CHAN_LO  = 8;
  localparam int ACC_A_CHAN_HI  = 9;
  localparam int ACC_B_RESET    = 0;
  localparam int ACC_B_STANDBY  = 1;
  localparam int ACC_B_JOINT    = 2;
  localparam int ACC_BB_BUF_EN  = 0;
  localparam int ACC_BB_LEVEL   = 1;
  localparam int ACC_BB_PIN_DIS = 2;
  localparam int ACC_BB_KEEP_ON = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       adc_power_on;
    logic       ramp_power_on;
    logic       gain_power_on;
    logic       freq_power_on;
    logic       freq_low_power;
    logic [1:0] adc_chan;
    logic       adc_start;
    logic       converters_reset;
  } acc_conv_ctrl_t;

  typedef struct packed {
    logic ref_power_on;
    logic ref_standby;
    logic ref_level_high;
    logic ref_buffer_on;
    logic ref_pin_drive;
  } acc_ref_ctrl_t;

  typedef struct packed {
    logic [7:0] main_word;
    logic [9:0] fine_word;
    logic       load;
  } acc_freq_dac_t;
endpackage : acc_pkg

//--- test/acc_chk_assertions.sv
// Purpose: Port assertions for acc_aux_converter_control
// Assumes: Zero wait-state APB
// Notes:   Bound to every instance
`timescale 1ns/100ps
`default_nettype none
module acc_chk
  import acc_pkg::*;
(
  // Clock, reset and bus
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [3:0]     pstrb,
  // Controls
  input wire acc_conv_ctrl_t conv_ctrl,
  input wire logic           conv_outputs_enable,
  input wire logic           freq_out_enable,
  input wire acc_freq_dac_t  freq_dac,
  input wire acc_ref_ctrl_t  ref_ctrl,
  input wire logic           buffered_ref_pin_oe
);
  logic        wr;
  logic        any_on;
  logic        joint_r;
  logic [31:0] pwdata_r;
  logic [7:0]  main_lat_r;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign any_on = |conv_ctrl[8:5];
  always_ff @(posedge pclk) pwdata_r <= pwdata;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) joint_r <= 1'b0;
    else if (wr && paddr == ACC_OFS_CTRL_B) joint_r <= pwdata[ACC_B_JOINT];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) main_lat_r <= 8'h00;
    else if (conv_ctrl.converters_reset) main_lat_r <= 8'h00;
    else if (wr && paddr == ACC_OFS_FMAIN) main_lat_r <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse;
    conv_ctrl.adc_start ##1 !conv_ctrl.adc_start;
  endsequence
  a_ctrl_a_load: assert property (wr && pstrb[1] && paddr == ACC_OFS_CTRL_A
    |=> conv_ctrl[8:2] == {pwdata_r[0], pwdata_r[1], pwdata_r[2], pwdata_r[3], pwdata_r[6],
    pwdata_r[9:8]}) else $error("ctrl A load");
  a_start_pulse: assert property (wr && pstrb[1] && paddr == ACC_OFS_CTRL_A && pwdata[7]
    && !conv_ctrl.converters_reset |=> s_pulse) else $error("start pulse");
  a_standby_gate: assert property (conv_outputs_enable == !ref_ctrl.ref_standby
    && freq_out_enable == conv_ctrl.freq_power_on) else $error("standby gating");
  a_ref_on: assert property (any_on && $past(any_on) && !ref_ctrl.ref_standby
    |-> ref_ctrl.ref_power_on) else $error("reference off");
  a_bb_load: assert property (wr && paddr == ACC_OFS_BB_B |=>
    {ref_ctrl[2:0], buffered_ref_pin_oe} == {pwdata_r[1],
    {3{pwdata_r[0] & ~pwdata_r[2]}}}) else $error("reference pin");
  a_reset_clears: assert property (conv_ctrl.converters_reset
    && $past(conv_ctrl.converters_reset) |-> freq_dac.main_word == 8'h00
    && freq_dac.fine_word == 10'h000 && !conv_ctrl.adc_start) else $error("reset hold");
  a_fine_load: assert property (wr && pstrb[1] && paddr == ACC_OFS_FFINE
    && !conv_ctrl.converters_reset |=> freq_dac.load
    && freq_dac.fine_word == pwdata_r[9:0]) else $error("fine load");
  a_main_load: assert property (wr && paddr == ACC_OFS_FMAIN && !conv_ctrl.converters_reset
    |=> freq_dac.main_word == (joint_r ? $past(freq_dac.main_word) : pwdata_r[7:0]))
    else $error("main load");
  a_joint_update: assert property (wr && pstrb[1] && paddr == ACC_OFS_FFINE && joint_r
    && !conv_ctrl.converters_reset |=> freq_dac.main_word == main_lat_r)
    else $error("joint update");
endmodule // acc_chk
bind acc_aux_converter_control acc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .conv_ctrl(conv_ctrl), .conv_outputs_enable(conv_outputs_enable),
  .freq_out_enable(freq_out_enable), .freq_dac(freq_dac), .ref_ctrl(ref_ctrl),
  .buffered_ref_pin_oe(buffered_ref_pin_oe));
`default_nettype wire

//--- test/tb.sv
// Purpose: Self-checking bench for acc_aux_converter_control
// Assumes: Zero wait-state APB slave
// Notes:   Port timing is left to the bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  import acc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        bb_on = 1'b0;
  logic        busy = 1'b0;
  logic        pready;
  logic        pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] v;
  logic [32:0] e_q;
  logic [32:0] expq[$];
  int          fails = 0;
  int          checked = 0;
  acc_aux_converter_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bb_conv_powered(bb_on),
    .aux_adc_busy(busy), .conv_ctrl(), .conv_outputs_enable(), .freq_out_enable(),
    .freq_dac(), .ref_ctrl(), .buffered_ref_pin_oe());
  initial forever #20 pclk = ~pclk;
  // ----------------------------------------
  // Bus tasks and read monitor
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0, 4'h0);
  endtask
  function automatic logic [32:0] st(input logic sb, input logic on);
    return {30'h0, busy, sb, on};
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) begin
      e_q = expq.pop_front();
      `CHK({pslverr, prdata}, e_q)
    end
  end
  task automatic complete_run();
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h2f9b));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    busy <= $urandom_range(1, 0);
    rd(ACC_OFS_CTRL_A, 33'h0);
    rd(ACC_OFS_CTRL_B, 33'h0);
    rd(ACC_OFS_STATUS, st(1'b0, 1'b0));
    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      v[9:8] = i[1:0];
      v[5:4] = 2'b00;
      xfer(1'b1, ACC_OFS_CTRL_A, v, 4'hf);
      rd(ACC_OFS_CTRL_A, {23'h0, v[9:0] & ACC_CTRL_A_WMASK});
      rd(ACC_OFS_STATUS, st(1'b0, |v[3:0]));
    end
    xfer(1'b1, ACC_OFS_CTRL_A, 32'h0, 4'h3);
    for (int i = 0; i < 16; i++) begin
      v = $urandom();
      v[3:0] = i[3:0];
      xfer(1'b1, ACC_OFS_BB_B, v, 4'h1);
      rd(ACC_OFS_BB_B, {29'h0, v[3:0]});
      rd(ACC_OFS_STATUS, st(1'b0, v[3]));
    end
    xfer(1'b1, ACC_OFS_BB_B, 32'h0, 4'h1);
    bb_on <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(ACC_OFS_STATUS, st(1'b0, 1'b1));
    bb_on <= 1'b0;
    xfer(1'b1, ACC_OFS_CTRL_B, 32'h006, 4'h3);
    rd(ACC_OFS_CTRL_B, 33'h6);
    rd(ACC_OFS_STATUS, st(1'b1, 1'b0));
    for (int i = 0; i < 2; i++) begin
      v = $urandom();
      xfer(1'b1, ACC_OFS_FMAIN, v, 4'hf);
      rd(ACC_OFS_FMAIN, {25'h0, v[7:0]});
      v = $urandom();
      xfer(1'b1, ACC_OFS_FFINE, v, 4'hf);
      rd(ACC_OFS_FFINE, {23'h0, v[9:0]});
      xfer(1'b1, ACC_OFS_CTRL_B, 32'h0, 4'h1);
    end
    xfer(1'b1, ACC_OFS_CTRL_B, 32'h1, 4'h1);
    rd(ACC_OFS_FMAIN, 33'h0);
    rd(ACC_OFS_FFINE, 33'h0);
    xfer(1'b1, ACC_OFS_CTRL_A, 32'h081, 4'h3);
    xfer(1'b1, ACC_OFS_CTRL_B, 32'h0, 4'h1);
    xfer(1'b1, ACC_OFS_CTRL_A, 32'h081, 4'h3);
    xfer(1'b1, ACC_OFS_CTRL_A, 32'h381, 4'h3);
    rd(ACC_OFS_CTRL_A, 33'h301);
    rd(8'h18, {1'b1, 32'h0});
    complete_run();
  end
endmodule // tb
`default_nettype wire
